// file: rtl/asrf_top.sv
// address and scalar register file core: entry decode, writes, reads
`timescale 1ns/1ps
module asrf_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// mode
	input wire logic legacy_mode_in,
	// entry from decode
	input wire logic entry_valid_in,
	input wire logic [3:0] entry_code_in,
	input wire logic [3:0] entry_dest_in,
	input wire logic [1:0] entry_cload_in,
	input wire logic [31:0] immediate_constant_in,
	input wire logic parcel_valid_in,
	input wire logic [15:0] parcel_in,
	output logic ext_refused_out,
	// functional unit and transfer results
	input wire logic [63:0] scalar_xfer_in,
	input wire logic [63:0] vector_length_value_in,
	input wire logic [63:0] inter_data_in,
	input wire logic [63:0] add_data_in,
	input wire logic [63:0] pop_data_in,
	input wire logic [63:0] mul_data_in,
	input wire logic [63:0] mask_data_in,
	input wire logic [63:0] vmask_data_in,
	input wire logic [63:0] logic_data_in,
	input wire logic [63:0] shift_data_in,
	output logic fu_sel_valid_out,
	output logic [3:0] fu_sel_out,
	// current parcel and hold
	input wire logic cip_valid_in,
	input wire logic cip_use_i_in,
	input wire logic cip_use_j_in,
	input wire logic cip_use_k_in,
	input wire logic [3:0] cip_i_in,
	input wire logic [3:0] cip_j_in,
	input wire logic [3:0] cip_k_in,
	output logic hold_issue_out,
	// operand reads
	input wire logic rd_valid_in,
	input wire logic [3:0] rd_i_in,
	input wire logic [3:0] rd_j_in,
	input wire logic [3:0] rd_k_in,
	output logic rd_valid_out,
	output logic [63:0] operand_i_out,
	output logic [63:0] scalar_operand_first_out,
	output logic [63:0] scalar_operand_second_out,
	// address register zero
	output logic [63:0] addr_reg_zero_out,
	output logic a0_is_zero_out,
	output logic a0_is_neg_out,
	// single word load
	input wire logic ld_req_in,
	input wire logic [3:0] ld_dest_in,
	input wire logic ld_cache_hit_in,
	input wire logic [63:0] ld_cache_data_in,
	input wire logic mem_rd_valid_in,
	input wire logic [63:0] mem_rd_data_in,
	output logic mem_rd_req_out,
	output logic ld_busy_out,
	// single word store
	input wire logic st_req_in,
	input wire logic [3:0] st_src_in,
	output logic st_valid_out,
	output logic [63:0] st_data_out
);
	asrf_slice_if sif [asrf_pkg::NUM_SLICES] ();

	////////////////////////////////////////////////////////////////////
	// entry acceptance

	logic prefix_armed_r;
	logic ext_refused_r;
	logic is_ext_op, ext_ok, take_entry;

	assign is_ext_op = !entry_dest_in[3] &&
		(entry_code_in == asrf_pkg::ASRF_EC_LOGIC ||
		entry_code_in == asrf_pkg::ASRF_EC_SHIFT);
	assign ext_ok = !is_ext_op || prefix_armed_r;
	assign take_entry = entry_valid_in && ext_ok;

	// the prefix only covers the parcel right after it
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			prefix_armed_r <= 1'b0;
		else if (parcel_valid_in)
			prefix_armed_r <= parcel_in == asrf_pkg::EXT_PREFIX;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			ext_refused_r <= 1'b0;
		else
			ext_refused_r <= entry_valid_in && !ext_ok;
	end
	assign ext_refused_out = ext_refused_r;

	////////////////////////////////////////////////////////////////////
	// delay chain

	logic done_valid;
	logic [3:0] done_dest, done_code;
	logic [1:0] done_cop;
	logic [31:0] done_imm;
	logic ld_busy_r;
	logic [3:0] ld_dest_r;

	asrf_chain #(.DEPTH(asrf_pkg::CHAIN_DEPTH)) u_chain (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.ins_valid_in(take_entry),
		.ins_lat_in(asrf_pkg::latency(entry_code_in)),
		.ins_dest_in(entry_dest_in),
		.ins_code_in(entry_code_in),
		.ins_cop_in(entry_cload_in),
		.ins_imm_in(immediate_constant_in),
		.done_valid_out(done_valid),
		.done_dest_out(done_dest),
		.done_code_out(done_code),
		.done_cop_out(done_cop),
		.done_imm_out(done_imm),
		.ld_busy_in(ld_busy_r),
		.ld_dest_in(ld_dest_r),
		.cip_valid_in(cip_valid_in),
		.cip_use_i_in(cip_use_i_in),
		.cip_use_j_in(cip_use_j_in),
		.cip_use_k_in(cip_use_k_in),
		.cip_i_in(cip_i_in),
		.cip_j_in(cip_j_in),
		.cip_k_in(cip_k_in),
		.hold_out(hold_issue_out)
	);

	////////////////////////////////////////////////////////////////////
	// slices and read ports

	logic [63:0] rd_word [asrf_pkg::NUM_RD];
	logic [3:0] ridx [asrf_pkg::NUM_RD];
	logic wr_en;
	logic [3:0] wr_idx;
	logic [63:0] wr_word;

	assign ridx[asrf_pkg::RP_I] = rd_i_in;
	assign ridx[asrf_pkg::RP_J] = rd_j_in;
	assign ridx[asrf_pkg::RP_K] = rd_k_in;
	assign ridx[asrf_pkg::RP_DEST] = done_dest;
	assign ridx[asrf_pkg::RP_A0] = asrf_pkg::IDX_A0;
	assign ridx[asrf_pkg::RP_ST] = st_src_in;

	for (genvar s = 0; s < asrf_pkg::NUM_SLICES; s++) begin : g_slice
		assign sif[s].we = wr_en;
		assign sif[s].widx = wr_idx;
		assign sif[s].wbyte = wr_word[s*8 +: 8];
		for (genvar p = 0; p < asrf_pkg::NUM_RD; p++) begin : g_port
			assign sif[s].ridx[p] = ridx[p];
			assign rd_word[p][s*8 +: 8] = sif[s].rbyte[p];
		end
		asrf_slice u_slice (
			.clk_in(clk_in),
			.resetn_in(resetn_in),
			.sl(sif[s])
		);
	end

	////////////////////////////////////////////////////////////////////
	// write source selection

	logic [63:0] cur, src_word, const_word, load_word, wr_src;
	logic src_known, chain_wr;

	assign cur = rd_word[asrf_pkg::RP_DEST];

	always_comb begin
		case (done_cop)
		asrf_pkg::ASRF_CL_FULL: const_word = {asrf_pkg::HALF_ZERO, done_imm};
		asrf_pkg::ASRF_CL_COMP: const_word = {asrf_pkg::HALF_ONES, ~done_imm};
		asrf_pkg::ASRF_CL_LOW: const_word = {cur[63:32], done_imm};
		asrf_pkg::ASRF_CL_UP: const_word = {done_imm, cur[31:0]};
		default: const_word = cur;
		endcase
	end

	always_comb begin
		src_known = 1'b1;
		case (done_code)
		asrf_pkg::ASRF_EC_CONST: src_word = const_word;
		asrf_pkg::ASRF_EC_SXFER: src_word = scalar_xfer_in;
		asrf_pkg::ASRF_EC_VLEN: src_word = vector_length_value_in;
		asrf_pkg::ASRF_EC_INTER: src_word = inter_data_in;
		asrf_pkg::ASRF_EC_ADD: src_word = add_data_in;
		asrf_pkg::ASRF_EC_POP: src_word = pop_data_in;
		asrf_pkg::ASRF_EC_MUL: src_word = mul_data_in;
		asrf_pkg::ASRF_EC_MASK: src_word = mask_data_in;
		asrf_pkg::ASRF_EC_VMASK: src_word = vmask_data_in;
		asrf_pkg::ASRF_EC_LOGIC: src_word = logic_data_in;
		asrf_pkg::ASRF_EC_SHIFT: src_word = shift_data_in;
		default: begin
			src_word = cur;
			src_known = 1'b0;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// single word loads; chain writes win, a load word waits while the chain writes

	logic ld_have_r;
	logic [63:0] ld_word_r;
	logic ld_wr;

	assign chain_wr = done_valid && src_known;
	assign ld_wr = ld_have_r && !chain_wr;
	assign load_word = ld_word_r;
	assign wr_en = chain_wr || ld_wr;
	assign wr_idx = chain_wr ? done_dest : ld_dest_r;
	assign wr_src = chain_wr ? src_word : load_word;
	// legacy mode keeps address registers to the low half
	assign wr_word = (!wr_idx[3] && legacy_mode_in) ?
		{asrf_pkg::HALF_ZERO, wr_src[31:0]} : wr_src;

	logic mem_rd_req_r;

	// one load outstanding at a time; one word per request
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ld_busy_r <= 1'b0;
			ld_have_r <= 1'b0;
			ld_dest_r <= 4'h0;
			ld_word_r <= 64'h0000_0000_0000_0000;
			mem_rd_req_r <= 1'b0;
		end else begin
			mem_rd_req_r <= ld_req_in && !ld_busy_r && !ld_cache_hit_in;
			if (ld_req_in && !ld_busy_r) begin
				ld_busy_r <= 1'b1;
				ld_dest_r <= ld_dest_in;
				ld_have_r <= ld_cache_hit_in;
				ld_word_r <= ld_cache_data_in;
			end else if (mem_rd_valid_in && ld_busy_r && !ld_have_r) begin
				ld_have_r <= 1'b1;
				ld_word_r <= mem_rd_data_in;
			end else if (ld_wr) begin
				ld_have_r <= 1'b0;
				ld_busy_r <= 1'b0;
			end
		end
	end
	assign mem_rd_req_out = mem_rd_req_r;
	assign ld_busy_out = ld_busy_r;

	////////////////////////////////////////////////////////////////////
	// operand reads with the register zero substitutes

	logic [63:0] op_j, op_k;

	assign op_j = (rd_j_in[2:0] == 3'h0) ? 64'h0000_0000_0000_0000 :
		rd_word[asrf_pkg::RP_J];
	assign op_k = (rd_k_in[2:0] != 3'h0) ? rd_word[asrf_pkg::RP_K] :
		(rd_k_in[3] ? asrf_pkg::S0_K_VALUE :
		asrf_pkg::A0_K_VALUE);

	logic rd_valid_r, st_valid_r, fu_sel_valid_r;
	logic [63:0] op_i_r, op_j_r, op_k_r, a0_r, st_data_r;
	logic a0_zero_r, a0_neg_r;
	logic [3:0] fu_sel_r;
	logic [63:0] a0_now;

	assign a0_now = rd_word[asrf_pkg::RP_A0];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_valid_r <= 1'b0;
			op_i_r <= 64'h0000_0000_0000_0000;
			op_j_r <= 64'h0000_0000_0000_0000;
			op_k_r <= 64'h0000_0000_0000_0000;
		end else begin
			rd_valid_r <= rd_valid_in;
			if (rd_valid_in) begin
				op_i_r <= rd_word[asrf_pkg::RP_I];
				op_j_r <= op_j;
				op_k_r <= op_k;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			a0_r <= 64'h0000_0000_0000_0000;
			a0_zero_r <= 1'b1;
			a0_neg_r <= 1'b0;
		end else begin
			a0_r <= a0_now;
			a0_zero_r <= a0_now == 64'h0000_0000_0000_0000;
			a0_neg_r <= legacy_mode_in ? a0_now[31] : a0_now[63];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_valid_r <= 1'b0;
			st_data_r <= 64'h0000_0000_0000_0000;
			fu_sel_valid_r <= 1'b0;
			fu_sel_r <= 4'h0;
		end else begin
			st_valid_r <= st_req_in;
			if (st_req_in)
				st_data_r <= rd_word[asrf_pkg::RP_ST];
			fu_sel_valid_r <= chain_wr;
			if (chain_wr)
				fu_sel_r <= done_code;
		end
	end

	assign rd_valid_out = rd_valid_r;
	assign operand_i_out = op_i_r;
	assign scalar_operand_first_out = op_j_r;
	assign scalar_operand_second_out = op_k_r;
	assign addr_reg_zero_out = a0_r;
	assign a0_is_zero_out = a0_zero_r;
	assign a0_is_neg_out = a0_neg_r;
	assign st_valid_out = st_valid_r;
	assign st_data_out = st_data_r;
	assign fu_sel_valid_out = fu_sel_valid_r;
	assign fu_sel_out = fu_sel_r;
endmodule

// file: rtl/asrf_pkg.sv
// constants shared by the address and scalar register file
package asrf_pkg;
	localparam int WORD_W = 64;
	localparam int HALF_W = 32;
	localparam int SLICE_W = 8;
	localparam int NUM_SLICES = 8;
	localparam int IDX_W = 4;
	localparam int NUM_RD = 6;
	localparam int CHAIN_DEPTH = 8;

	// register index: bit 3 picks the scalar bank
	localparam logic [IDX_W-1:0] IDX_A0 = 4'h0;
	localparam logic [IDX_W-1:0] IDX_S0 = 4'h8;

	// read port numbers inside every slice
	localparam int RP_I = 0;
	localparam int RP_J = 1;
	localparam int RP_K = 2;
	localparam int RP_DEST = 3;
	localparam int RP_A0 = 4;
	localparam int RP_ST = 5;

	typedef enum logic [3:0] {
		ASRF_EC_CONST = 4'h0,
		ASRF_EC_SXFER = 4'h1,
		ASRF_EC_VLEN = 4'h2,
		ASRF_EC_INTER = 4'h3,
		ASRF_EC_ADD = 4'h4,
		ASRF_EC_POP = 4'h5,
		ASRF_EC_MUL = 4'h6,
		ASRF_EC_MASK = 4'h7,
		ASRF_EC_VMASK = 4'h9,
		ASRF_EC_LOGIC = 4'hc,
		ASRF_EC_SHIFT = 4'he
	} asrf_code_t;

	typedef enum logic [1:0] {
		ASRF_CL_FULL = 2'h0,
		ASRF_CL_COMP = 2'h1,
		ASRF_CL_LOW = 2'h2,
		ASRF_CL_UP = 2'h3
	} asrf_cload_t;

	localparam logic [15:0] EXT_PREFIX = 16'h0b00;
	localparam logic [WORD_W-1:0] A0_K_VALUE = 64'h0000_0000_0000_0001;
	localparam logic [WORD_W-1:0] S0_K_VALUE = 64'h8000_0000_0000_0000;
	localparam logic [HALF_W-1:0] HALF_ONES = 32'hffff_ffff;
	localparam logic [HALF_W-1:0] HALF_ZERO = 32'h0000_0000;

	// cycles from entry to the write into the destination
	localparam logic [2:0] LAT_ADD = 3'h4;
	localparam logic [2:0] LAT_MUL = 3'h6;
	localparam logic [2:0] LAT_SHIFT = 3'h2;
	localparam logic [2:0] LAT_ONE = 3'h1;

	function automatic logic [2:0] latency(input logic [3:0] code);
		logic [2:0] l;
		l = LAT_ONE;
		if (code == ASRF_EC_ADD)
			l = LAT_ADD;
		else if (code == ASRF_EC_MUL)
			l = LAT_MUL;
		else if (code == ASRF_EC_SHIFT || code == ASRF_EC_POP)
			l = LAT_SHIFT;
		return l;
	endfunction
endpackage

// file: rtl/asrf_slice_if.sv
// write and read port bundle between the core and one register slice
`timescale 1ns/1ps
interface asrf_slice_if;
	logic we;
	logic [asrf_pkg::IDX_W-1:0] widx;
	logic [asrf_pkg::SLICE_W-1:0] wbyte;
	logic [asrf_pkg::IDX_W-1:0] ridx [asrf_pkg::NUM_RD];
	logic [asrf_pkg::SLICE_W-1:0] rbyte [asrf_pkg::NUM_RD];

	modport core (output we, output widx, output wbyte, output ridx,
		input rbyte);
	modport slice (input we, input widx, input wbyte, input ridx,
		output rbyte);
endinterface

// file: rtl/asrf_slice.sv
// one byte slice of all sixteen address and scalar registers
`timescale 1ns/1ps
module asrf_slice (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// ports from the core
	asrf_slice_if.slice sl
);
	localparam int NREG = 16;
	logic [asrf_pkg::SLICE_W-1:0] mem_r [NREG];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int n = 0; n < NREG; n++)
				mem_r[n] <= 8'h00;
		end else if (sl.we) begin
			mem_r[sl.widx] <= sl.wbyte;
		end
	end

	for (genvar p = 0; p < asrf_pkg::NUM_RD; p++) begin : g_rd
		assign sl.rbyte[p] = mem_r[sl.ridx[p]];
	end
endmodule

// file: rtl/asrf_chain.sv
// destination delay chain, reservations and issue hold
`timescale 1ns/1ps
module asrf_chain #(
	parameter int DEPTH = asrf_pkg::CHAIN_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// new entry
	input wire logic ins_valid_in,
	input wire logic [2:0] ins_lat_in,
	input wire logic [3:0] ins_dest_in,
	input wire logic [3:0] ins_code_in,
	input wire logic [1:0] ins_cop_in,
	input wire logic [31:0] ins_imm_in,
	// completing entry
	output logic done_valid_out,
	output logic [3:0] done_dest_out,
	output logic [3:0] done_code_out,
	output logic [1:0] done_cop_out,
	output logic [31:0] done_imm_out,
	// outstanding load
	input wire logic ld_busy_in,
	input wire logic [3:0] ld_dest_in,
	// current parcel operand use
	input wire logic cip_valid_in,
	input wire logic cip_use_i_in,
	input wire logic cip_use_j_in,
	input wire logic cip_use_k_in,
	input wire logic [3:0] cip_i_in,
	input wire logic [3:0] cip_j_in,
	input wire logic [3:0] cip_k_in,
	output logic hold_out
);
	if (DEPTH < 7 || DEPTH > 8) begin : g_bad_depth
		$error("chain depth must cover the longest latency");
	end

	logic [DEPTH-1:0] v_r;
	logic [3:0] d_r [DEPTH];
	logic [3:0] c_r [DEPTH];
	logic [1:0] o_r [DEPTH];
	logic [31:0] m_r [DEPTH];
	logic [15:0] resv;
	logic hold_r;
	logic [2:0] ins_pos;

	assign ins_pos = ins_lat_in - 3'h1;

	// stage 0 is the write stage; entries walk down one per cycle
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			v_r <= '0;
			for (int s = 0; s < DEPTH; s++) begin
				d_r[s] <= 4'h0;
				c_r[s] <= 4'h0;
				o_r[s] <= 2'h0;
				m_r[s] <= 32'h0000_0000;
			end
		end else begin
			for (int s = 0; s < DEPTH; s++) begin
				if (ins_valid_in && s == int'(ins_pos)) begin
					v_r[s] <= 1'b1;
					d_r[s] <= ins_dest_in;
					c_r[s] <= ins_code_in;
					o_r[s] <= ins_cop_in;
					m_r[s] <= ins_imm_in;
				end else if (s < DEPTH - 1) begin
					v_r[s] <= v_r[s+1];
					d_r[s] <= d_r[s+1];
					c_r[s] <= c_r[s+1];
					o_r[s] <= o_r[s+1];
					m_r[s] <= m_r[s+1];
				end else begin
					v_r[s] <= 1'b0;
				end
			end
		end
	end

	assign done_valid_out = v_r[0];
	assign done_dest_out = d_r[0];
	assign done_code_out = c_r[0];
	assign done_cop_out = o_r[0];
	assign done_imm_out = m_r[0];

	// a destination stays reserved while in flight, incl. the write cycle
	always_comb begin
		resv = 16'h0000;
		for (int s = 0; s < DEPTH; s++)
			if (v_r[s])
				resv[d_r[s]] = 1'b1;
		if (ld_busy_in)
			resv[ld_dest_in] = 1'b1;
		if (ins_valid_in)
			resv[ins_dest_in] = 1'b1;
	end

	logic need_i, need_j, need_k;
	assign need_i = cip_use_i_in && resv[cip_i_in];
	assign need_j = cip_use_j_in && resv[cip_j_in] &&
		cip_j_in[2:0] != 3'h0;
	assign need_k = cip_use_k_in && resv[cip_k_in] &&
		cip_k_in[2:0] != 3'h0;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			hold_r <= 1'b0;
		else
			hold_r <= cip_valid_in && (need_i || need_j || need_k);
	end
	assign hold_out = hold_r;
endmodule

// file: verification/asrf_top_props.sv
// concurrent checks on the register file core ports
`timescale 1ns/1ps
module asrf_top_props (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// entry and issue
	input wire logic entry_valid_in,
	input wire logic [3:0] entry_code_in,
	input wire logic [3:0] entry_dest_in,
	input wire logic ext_refused_out,
	input wire logic fu_sel_valid_out,
	input wire logic [3:0] fu_sel_out,
	input wire logic cip_valid_in,
	input wire logic cip_use_i_in,
	input wire logic [3:0] cip_i_in,
	input wire logic hold_issue_out,
	// reads
	input wire logic rd_valid_in,
	input wire logic [3:0] rd_i_in,
	input wire logic [3:0] rd_j_in,
	input wire logic [3:0] rd_k_in,
	input wire logic rd_valid_out,
	input wire logic [63:0] operand_i_out,
	input wire logic [63:0] scalar_operand_first_out,
	input wire logic [63:0] scalar_operand_second_out,
	input wire logic [63:0] addr_reg_zero_out,
	input wire logic a0_is_zero_out,
	// memory paths
	input wire logic ld_req_in,
	input wire logic ld_cache_hit_in,
	input wire logic ld_busy_out,
	input wire logic mem_rd_req_out,
	input wire logic st_req_in,
	input wire logic st_valid_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_add_done: assert property (entry_valid_in && entry_code_in == 4'h4
		|-> ##5 fu_sel_valid_out && fu_sel_out == 4'h4)
		else $error("add result select missing");
	a_mul_done: assert property (entry_valid_in && entry_code_in == 4'h6
		|-> ##7 fu_sel_valid_out && fu_sel_out == 4'h6)
		else $error("multiply result select missing");
	a_const_done: assert property (entry_valid_in && entry_code_in == 4'h0
		|-> ##2 fu_sel_valid_out && fu_sel_out == 4'h0)
		else $error("constant write select missing");
	a_refuse_cause: assert property (ext_refused_out
		|-> $past(entry_valid_in) && $past(entry_code_in[3:2]) == 2'b11
		&& !$past(entry_dest_in[3]))
		else $error("refusal without extended address entry");
	a_hold_dest: assert property (entry_valid_in && entry_dest_in[3]
		&& entry_dest_in != 4'h8 && cip_valid_in && cip_use_i_in
		&& cip_i_in == entry_dest_in |=> hold_issue_out)
		else $error("reserved destination did not hold issue");
	a_read_answer: assert property (rd_valid_in |=> rd_valid_out)
		else $error("read answer missing");
	a_j_zero: assert property (rd_valid_in && rd_j_in[2:0] == 3'h0
		|=> scalar_operand_first_out == 64'h0)
		else $error("j operand of register zero not zero");
	a_k_scalar: assert property (rd_valid_in && rd_k_in == 4'h8
		|=> scalar_operand_second_out == 64'h8000_0000_0000_0000)
		else $error("k operand of scalar zero wrong");
	a_k_addr: assert property (rd_valid_in && rd_k_in == 4'h0
		|=> scalar_operand_second_out == 64'h1)
		else $error("k operand of address zero wrong");
	a_i_a0: assert property (rd_valid_in && rd_i_in == 4'h0
		|=> operand_i_out == addr_reg_zero_out)
		else $error("i operand of address zero not its contents");
	a_a0_test: assert property (a0_is_zero_out
		== (addr_reg_zero_out == 64'h0))
		else $error("zero test of address zero wrong");
	a_miss_req: assert property (ld_req_in && !ld_busy_out
		&& !ld_cache_hit_in |=> mem_rd_req_out)
		else $error("miss made no memory read");
	a_hit_quiet: assert property (ld_req_in && !ld_busy_out
		&& ld_cache_hit_in |=> !mem_rd_req_out [*2])
		else $error("cache hit made a memory read");
	a_store_one: assert property (st_valid_out == $past(st_req_in))
		else $error("store word count wrong");

	c_refused: cover property (ext_refused_out);
	c_hold: cover property (hold_issue_out);
	c_miss: cover property (mem_rd_req_out);
	c_store: cover property (st_valid_out);
endmodule

bind asrf_top asrf_top_props asrf_top_props_inst (.clk_in(clk_in),
	.resetn_in(resetn_in), .entry_valid_in(entry_valid_in),
	.entry_code_in(entry_code_in), .entry_dest_in(entry_dest_in),
	.ext_refused_out(ext_refused_out), .fu_sel_valid_out(fu_sel_valid_out),
	.fu_sel_out(fu_sel_out), .cip_valid_in(cip_valid_in),
	.cip_use_i_in(cip_use_i_in), .cip_i_in(cip_i_in),
	.hold_issue_out(hold_issue_out), .rd_valid_in(rd_valid_in),
	.rd_i_in(rd_i_in), .rd_j_in(rd_j_in), .rd_k_in(rd_k_in),
	.rd_valid_out(rd_valid_out), .operand_i_out(operand_i_out),
	.scalar_operand_first_out(scalar_operand_first_out),
	.scalar_operand_second_out(scalar_operand_second_out),
	.addr_reg_zero_out(addr_reg_zero_out), .a0_is_zero_out(a0_is_zero_out),
	.ld_req_in(ld_req_in), .ld_cache_hit_in(ld_cache_hit_in),
	.ld_busy_out(ld_busy_out), .mem_rd_req_out(mem_rd_req_out),
	.st_req_in(st_req_in), .st_valid_out(st_valid_out));

// file: verification/asrf_mem_model.sv
// memory side partner: one word back for each read request
`timescale 1ns/1ps
module asrf_mem_model #(
	parameter int DELAY = 3
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// request and the word to return
	input wire logic req_in,
	input wire logic [63:0] word_in,
	// answer
	output logic valid_out,
	output logic [63:0] data_out
);
	int cnt_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 0;
			valid_out <= 1'b0;
			data_out <= 64'h0;
		end else begin
			valid_out <= 1'b0;
			// idle bus toggles so stale data never looks valid
			data_out <= ~data_out;
			if (req_in)
				cnt_r <= DELAY;
			else if (cnt_r > 0)
				cnt_r <= cnt_r - 1;
			if (cnt_r == 1) begin
				valid_out <= 1'b1;
				data_out <= word_in;
			end
		end
	end
endmodule

// file: verification/asrf_top_tb.sv
// self-checking bench for the address and scalar register file
`timescale 1ns/1ps
module asrf_top_tb;
	logic clk_in = 0, resetn_in = 0, legacy = 0, ev = 0, pv = 0, rv = 0;
	logic lr = 0, hit = 0, sr = 0, cv = 0, ui = 0, uj = 0, uk = 0;
	logic [3:0] code = 0, dest = 0, ci = 0, cj = 0, ck = 0, ri = 0, rj = 0;
	logic [3:0] rk = 0, ldd = 0, ss = 0, fs;
	logic [1:0] cl = 0;
	logic [31:0] imm = 0, r;
	logic [15:0] parcel = 0;
	logic [63:0] sd [10] = '{default: 64'h0};
	logic [63:0] regs [16] = '{default: 64'h0};
	logic [63:0] cdat = 0, mw = 0, mdat, oi, oj, ok, a0, std;
	logic mv, mreq, ext_ref, fsv, hold, rvo, zo, neg, busy, stv;
	int fails = 0, n_checks = 0, cyc = 0, seed = 41796, nreq = 0;
	int slot [16] = '{0, 0, 1, 2, 3, 4, 5, 6, 10, 7, 10, 10, 8, 10, 9, 10};

	asrf_top asrf_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.legacy_mode_in(legacy), .entry_valid_in(ev), .entry_code_in(code),
		.entry_dest_in(dest), .entry_cload_in(cl), .immediate_constant_in(imm),
		.parcel_valid_in(pv), .parcel_in(parcel), .ext_refused_out(ext_ref),
		.scalar_xfer_in(sd[0]), .vector_length_value_in(sd[1]),
		.inter_data_in(sd[2]), .add_data_in(sd[3]), .pop_data_in(sd[4]),
		.mul_data_in(sd[5]), .mask_data_in(sd[6]), .vmask_data_in(sd[7]),
		.logic_data_in(sd[8]), .shift_data_in(sd[9]), .fu_sel_valid_out(fsv),
		.fu_sel_out(fs), .cip_valid_in(cv), .cip_use_i_in(ui),
		.cip_use_j_in(uj), .cip_use_k_in(uk), .cip_i_in(ci), .cip_j_in(cj),
		.cip_k_in(ck), .hold_issue_out(hold), .rd_valid_in(rv), .rd_i_in(ri),
		.rd_j_in(rj), .rd_k_in(rk), .rd_valid_out(rvo), .operand_i_out(oi),
		.scalar_operand_first_out(oj), .scalar_operand_second_out(ok),
		.addr_reg_zero_out(a0), .a0_is_zero_out(zo), .a0_is_neg_out(neg),
		.ld_req_in(lr), .ld_dest_in(ldd), .ld_cache_hit_in(hit),
		.ld_cache_data_in(cdat), .mem_rd_valid_in(mv), .mem_rd_data_in(mdat),
		.mem_rd_req_out(mreq), .ld_busy_out(busy), .st_req_in(sr),
		.st_src_in(ss), .st_valid_out(stv), .st_data_out(std));

	asrf_mem_model #(.DELAY(3)) asrf_mem_model_inst (.clk_in(clk_in),
		.resetn_in(resetn_in), .req_in(mreq), .word_in(mw), .valid_out(mv),
		.data_out(mdat));

	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cyc++;
		if (mreq === 1'b1)
			nreq++;
		if (cyc == 5000) begin
			fails++;
			end_sim;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [63:0] cl_val(input logic [1:0] f,
		input logic [31:0] n, input logic [63:0] old);
		case (f)
			2'h0: return {32'h0, n};
			2'h1: return {32'hffff_ffff, ~n};
			2'h2: return {old[63:32], n};
			default: return {n, old[31:0]};
		endcase
	endfunction

	// unused codes leave the destination as it was
	function automatic logic [63:0] src_val(input logic [3:0] c,
		input logic [63:0] old);
		return slot[c] > 9 ? old : sd[slot[c]];
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic put(input logic [3:0] c, input logic [3:0] d,
		input logic [1:0] f, input logic pre);
		logic [63:0] e;
		logic rf;
		@(posedge clk_in);
		pv <= 1'b1;
		parcel <= pre ? 16'h0b00 : 16'h1234;
		imm <= $random(seed);
		foreach (sd[x])
			sd[x] <= {$random(seed), $random(seed)};
		@(posedge clk_in);
		pv <= 1'b0;
		ev <= 1'b1;
		code <= c;
		dest <= d;
		cl <= f;
		@(posedge clk_in);
		ev <= 1'b0;
		@(negedge clk_in);
		rf = c[3:2] == 2'b11 && !c[0] && !d[3] && !pre;
		e = c == 4'h0 ? cl_val(f, imm, regs[d]) : src_val(c, regs[d]);
		if (!d[3] && legacy)
			e[63:32] = 32'h0;
		chk({63'h0, ext_ref}, {63'h0, rf});
		regs[d] = rf ? regs[d] : e;
		repeat (8) @(posedge clk_in);
	endtask

	task automatic get(input logic [3:0] i, input logic [3:0] j,
		input logic [3:0] k);
		@(posedge clk_in);
		rv <= 1'b1;
		ri <= i;
		rj <= j;
		rk <= k;
		@(posedge clk_in);
		rv <= 1'b0;
		@(negedge clk_in);
		chk(oi, regs[i]);
		chk(oj, j[2:0] == 3'h0 ? 64'h0 : regs[j]);
		chk(ok, k == 4'h0 ? 64'h1 : k == 4'h8 ? 64'h8000_0000_0000_0000
			: regs[k]);
	endtask

	task automatic load(input logic [3:0] d, input logic h);
		int n;
		n = nreq;
		@(posedge clk_in);
		lr <= 1'b1;
		ldd <= d;
		hit <= h;
		cdat <= {$random(seed), $random(seed)};
		mw <= {$random(seed), $random(seed)};
		@(posedge clk_in);
		lr <= 1'b0;
		repeat (12) @(posedge clk_in);
		regs[d] = h ? cdat : mw;
		chk(64'(nreq - n), {63'h0, !h});
		get(d, d, d);
		@(posedge clk_in);
		sr <= 1'b1;
		ss <= d;
		@(posedge clk_in);
		sr <= 1'b0;
		@(negedge clk_in);
		chk(std, regs[d]);
	endtask

	task automatic resv(input logic [3:0] d, input logic [2:0] u,
		input logic exp);
		@(posedge clk_in);
		ev <= 1'b1;
		code <= 4'h4;
		dest <= d;
		cv <= 1'b1;
		{ui, uj, uk} <= u;
		ci <= d;
		cj <= d;
		ck <= d;
		@(posedge clk_in);
		ev <= 1'b0;
		cv <= 1'b0;
		@(negedge clk_in);
		chk({63'h0, hold}, {63'h0, exp});
		regs[d] = sd[3];
		repeat (8) @(posedge clk_in);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_in);
		resetn_in <= 1'b1;
		// odd trip: code c unprefixed, code e prefixed
		for (int c = 0; c < 16; c++) begin
			put(c[3:0], 4'h9, 2'h0, 1'b0);
			get(4'h9, 4'h9, 4'h1);
			put(c[3:0], 4'h2, 2'h0, c[1]);
			get(4'h2, 4'h2, 4'h2);
		end
		for (int f = 0; f < 4; f++) begin
			put(4'h0, 4'hb, f[1:0], 1'b0);
			get(4'hb, 4'h8, 4'h8);
		end
		legacy <= 1'b1;
		put(4'h1, 4'h3, 2'h0, 1'b0);
		legacy <= 1'b0;
		get(4'h3, 4'h0, 4'h3);
		put(4'h1, 4'h0, 2'h0, 1'b0);
		get(4'h0, 4'h0, 4'h0);
		chk({63'h0, zo}, {63'h0, regs[0] == 64'h0});
		chk({63'h0, neg}, {63'h0, regs[0][63]});
		load(4'hc, 1'b1);
		load(4'h5, 1'b0);
		resv(4'hd, 3'b100, 1'b1);
		resv(4'h8, 3'b011, 1'b0);
		repeat (20) begin
			r = $random(seed);
			put(r[3:0], r[7:4], r[9:8], r[10]);
			get(r[7:4], r[11:8], r[15:12]);
		end
		end_sim;
	end
endmodule
